// file: hw/irq_logic_regs.vh
// Register offsets, field positions, reset values and vectors of the interrupt logic
`ifndef IRQ_LOGIC_REGS_VH
`define IRQ_LOGIC_REGS_VH

// Avalon-MM word offsets (byte address = 4 * index)
`define OFS_IRQ_STATUS     4'h0
`define OFS_TIMER_STATUS   4'h1
`define OFS_CPU_STATUS     4'h2
`define OFS_PERIPH_FLAG    4'h3
`define OFS_PERIPH_ENABLE  4'h4
`define OFS_VECTOR         4'h5

// irq_status_reg fields
`define BIT_EXT_PIN_ENABLE    0
`define BIT_TMR_OVF_ENABLE    1
`define BIT_COUNT_PIN_ENABLE  2
`define BIT_PERIPH_GRP_ENABLE 3
`define BIT_EXT_PIN_FLAG      4
`define BIT_TMR_OVF_FLAG      5
`define BIT_COUNT_PIN_FLAG    6
`define BIT_PERIPH_SUM_FLAG   7

// timer_status_reg fields
`define BIT_EXT_EDGE_SELECT   7
`define BIT_COUNT_EDGE_SELECT 6

// cpu status field
`define BIT_GLOBAL_DISABLE    4

// Reset values
`define RST_IRQ_STATUS   8'h00
`define RST_TIMER_STATUS 8'h00
`define RST_PERIPH_FLAG  8'h00
`define RST_PERIPH_EN    8'h00

// Vector addresses
`define VEC_NONE      16'h0000
`define VEC_EXT_PIN   16'h0008
`define VEC_TMR_OVF   16'h0010
`define VEC_COUNT_PIN 16'h0018
`define VEC_PERIPH    16'h0020

`endif

// file: hw/pin_edge_detect.v
// Pin synchroniser and selectable edge detector
`timescale 1ns/10ps
module pin_edge_detect (
    input  wire core_clk,
    input  wire nrst,
    input  wire pin,
    input  wire rise_sel,
    output reg  edge_pulse
);
    reg [2:0] sync;
    reg       stable;
    reg       stable_d;
    reg [1:0] fill;

    always @(posedge core_clk) begin
        if (!nrst) begin
            sync       <= 3'h0;
            stable     <= 1'b0;
            stable_d   <= 1'b0;
            fill       <= 2'h0;
            edge_pulse <= 1'b0;
        end else begin
            sync <= {sync[1:0], pin};
            if (fill != 2'h3) begin
                // Follow the pin silently after reset, no false edge
                fill       <= fill + 2'h1;
                stable     <= sync[1];
                stable_d   <= sync[1];
                edge_pulse <= 1'b0;
            end else begin
                // Accept a change once stages two and three agree
                if (sync[1] == sync[2])
                    stable <= sync[2];
                stable_d   <= stable;
                edge_pulse <= rise_sel ? (stable & ~stable_d) : (~stable & stable_d);
            end
        end
    end
endmodule // pin_edge_detect

// file: hw/four_vector_interrupt_logic.v
// Four-vector interrupt logic with Avalon-MM register access
//
// The register addresses and the Avalon-MM register port were decided locally.
`timescale 1ns/10ps
`include "irq_logic_regs.vh"

// Summary of operation
// - Vectors 0008h ext pin, 0010h timer, 0018h count pin, 0020h peripherals.
// - Fixed priority: ext pin first, then timer, count pin, peripherals last.
// - Flags set on events regardless of enables or global disable.
// - Ext pin edge: rising when edge select bit 7 set, else falling.
// - Valid ext pin edge sets status bit 4.
// - Ext pin interrupt masked while status bit 0 clear.
// - Enabled ext pin interrupt wakes the core from sleep.
// - Count pin edge: rising when timer status bit 6 set, else falling.
// - Valid count pin edge sets status bit 6.
// - Count pin interrupt masked while status bit 2 clear.
// - Enabled count pin interrupt wakes the core from sleep.
// - Peripheral summary flag is read-only OR of flag AND enable.
// - Enabled peripheral sources wake the core via the summary.
// - Entry saves only the return address on the stack.
// - Taking an interrupt sets global disable, pushes return, loads vector.
// - Return from interrupt clears global disable and pops the program counter unless an interrupt is taken in the same cycle.
// - Reset sets global disable.
// - Simultaneous pending interrupts vector to highest priority first.
module four_vector_interrupt_logic (
    input  wire        core_clk,
    input  wire        nrst,
    // Avalon-MM slave
    input  wire [3:0]  address,
    input  wire        read,
    input  wire        write,
    input  wire [31:0] writedata,
    input  wire [3:0]  byteenable,
    output reg  [31:0] readdata,
    output wire        waitrequest,
    // Pins
    input  wire        ext_irq_pin,
    input  wire        timer_clock_pin,
    // Timer and peripheral events
    input  wire        timer_overflow_event,
    input  wire [7:0]  periph_event,
    // Core sequencer
    input  wire        irq_ack,
    input  wire        return_from_irq,
    input  wire [15:0] return_pc,
    input  wire        core_sleeping,
    output wire        irq_request,
    output reg  [15:0] irq_vector,
    output reg         stack_push,
    output reg  [15:0] stack_push_data,
    output reg         stack_pop,
    output wire        wake
);
    reg  [7:0] irq_status_reg;
    reg  [7:0] timer_status_reg;
    reg        global_irq_disable;
    reg  [7:0] periph_flag_regs;
    reg  [7:0] periph_enable_regs;
    reg        bus_ack;

    wire ext_pin_edge;
    wire count_pin_edge;

    wire ext_pin_enable      = irq_status_reg[`BIT_EXT_PIN_ENABLE];
    wire tmr_ovf_enable      = irq_status_reg[`BIT_TMR_OVF_ENABLE];
    wire count_pin_enable    = irq_status_reg[`BIT_COUNT_PIN_ENABLE];
    wire periph_group_enable = irq_status_reg[`BIT_PERIPH_GRP_ENABLE];
    wire ext_pin_flag        = irq_status_reg[`BIT_EXT_PIN_FLAG];
    wire timer_overflow_flag = irq_status_reg[`BIT_TMR_OVF_FLAG];
    wire count_pin_flag      = irq_status_reg[`BIT_COUNT_PIN_FLAG];
    wire periph_summary_flag = |(periph_flag_regs & periph_enable_regs);
    wire ext_edge_select       = timer_status_reg[`BIT_EXT_EDGE_SELECT];
    wire count_pin_edge_select = timer_status_reg[`BIT_COUNT_EDGE_SELECT];

    // Per-source pending, ignoring global disable
    wire ext_pend    = ext_pin_flag & ext_pin_enable;
    wire tmr_pend    = timer_overflow_flag & tmr_ovf_enable;
    wire count_pend  = count_pin_flag & count_pin_enable;
    wire periph_pend = periph_summary_flag & periph_group_enable;

    pin_edge_detect ext_det (
        .core_clk   (core_clk),
        .nrst       (nrst),
        .pin        (ext_irq_pin),
        .rise_sel   (ext_edge_select),
        .edge_pulse (ext_pin_edge)
    );

    pin_edge_detect count_det (
        .core_clk   (core_clk),
        .nrst       (nrst),
        .pin        (timer_clock_pin),
        .rise_sel   (count_pin_edge_select),
        .edge_pulse (count_pin_edge)
    );

    wire any_pend = ext_pend | tmr_pend | count_pend | periph_pend;
    assign irq_request = any_pend & ~global_irq_disable;
    // Wake ignores global disable so a masked core still leaves sleep
    wire ext_wake    = ext_pend;
    wire tmr_wake    = tmr_pend;
    wire count_wake  = count_pend;
    wire periph_wake = periph_pend;
    assign wake = core_sleeping & (ext_wake | tmr_wake | count_wake | periph_wake);

    // One-hot grant of the highest-priority pending source
    wire [3:0] pend_vec = {periph_pend, count_pend, tmr_pend, ext_pend};
    reg  [3:0] grant;

    always @* begin
        grant = 4'h0;
        if (pend_vec[0])
            grant = 4'h1;
        else if (pend_vec[1])
            grant = 4'h2;
        else if (pend_vec[2])
            grant = 4'h4;
        else if (pend_vec[3])
            grant = 4'h8;
        else
            grant = 4'h0;
    end

    // Vector of the granted source
    always @* begin
        case (grant)
            4'h1: begin
                irq_vector = `VEC_EXT_PIN;
            end
            4'h2: begin
                irq_vector = `VEC_TMR_OVF;
            end
            4'h4: begin
                irq_vector = `VEC_COUNT_PIN;
            end
            4'h8: begin
                irq_vector = `VEC_PERIPH;
            end
            default: begin
                irq_vector = `VEC_NONE;
            end
        endcase
    end

    // Bus: one wait cycle, answer on the second edge
    wire bus_req  = read | write;
    assign waitrequest = bus_req & ~bus_ack;
    wire wr_take  = write & bus_ack;
    wire wr_lane0 = wr_take & byteenable[0];

    // Per-register write strobes, true only on the accepting edge
    wire wr_irq_status    = wr_lane0 & (address == `OFS_IRQ_STATUS);
    wire wr_timer_status  = wr_lane0 & (address == `OFS_TIMER_STATUS);
    wire wr_cpu_status    = wr_lane0 & (address == `OFS_CPU_STATUS);
    wire wr_periph_flag   = wr_lane0 & (address == `OFS_PERIPH_FLAG);
    wire wr_periph_enable = wr_lane0 & (address == `OFS_PERIPH_ENABLE);

    always @(posedge core_clk) begin
        if (!nrst) begin
            bus_ack <= 1'b0;
        end else begin
            bus_ack <= bus_req & ~bus_ack;
        end
    end

    // Read mux, captured into readdata during the wait cycle
    reg [31:0] next_readdata;
    always @* begin
        next_readdata = 32'h00000000;
        case (address)
            `OFS_IRQ_STATUS: begin
                next_readdata[7:0] = {periph_summary_flag, irq_status_reg[6:0]};
            end
            `OFS_TIMER_STATUS: begin
                next_readdata[7:0] = timer_status_reg;
            end
            `OFS_CPU_STATUS: begin
                next_readdata[`BIT_GLOBAL_DISABLE] = global_irq_disable;
            end
            `OFS_PERIPH_FLAG: begin
                next_readdata[7:0] = periph_flag_regs;
            end
            `OFS_PERIPH_ENABLE: begin
                next_readdata[7:0] = periph_enable_regs;
            end
            `OFS_VECTOR: begin
                next_readdata[15:0] = irq_vector;
            end
            default: begin
                next_readdata = 32'h00000000;
            end
        endcase
    end

    always @(posedge core_clk) begin
        if (!nrst) begin
            readdata <= 32'h00000000;
        end else if (read && !bus_ack) begin
            readdata <= next_readdata;
        end
    end

    // Status register: hardware set wins over software write
    reg [7:0] next_status;
    always @* begin
        next_status = irq_status_reg;
        if (wr_irq_status)
            next_status[6:0] = writedata[6:0];
        // Summary bit is never stored; reads show the live OR
        next_status[`BIT_PERIPH_SUM_FLAG] = 1'b0;
        if (ext_pin_edge)
            next_status[`BIT_EXT_PIN_FLAG] = 1'b1;
        if (timer_overflow_event)
            next_status[`BIT_TMR_OVF_FLAG] = 1'b1;
        if (count_pin_edge)
            next_status[`BIT_COUNT_PIN_FLAG] = 1'b1;
    end

    always @(posedge core_clk) begin
        if (!nrst) begin
            irq_status_reg <= `RST_IRQ_STATUS;
        end else begin
            irq_status_reg <= next_status;
        end
    end

    reg [7:0] next_pflag;
    always @* begin
        next_pflag = periph_flag_regs;
        if (wr_periph_flag)
            next_pflag = writedata[7:0];
        next_pflag = next_pflag | periph_event;
    end

    always @(posedge core_clk) begin
        if (!nrst) begin
            periph_flag_regs <= `RST_PERIPH_FLAG;
        end else begin
            periph_flag_regs <= next_pflag;
        end
    end

    reg [7:0] next_timer_status;
    always @* begin
        next_timer_status = timer_status_reg;
        if (wr_timer_status)
            next_timer_status = writedata[7:0];
    end

    always @(posedge core_clk) begin
        if (!nrst) begin
            timer_status_reg <= `RST_TIMER_STATUS;
        end else begin
            timer_status_reg <= next_timer_status;
        end
    end

    reg [7:0] next_periph_enable;
    always @* begin
        next_periph_enable = periph_enable_regs;
        if (wr_periph_enable)
            next_periph_enable = writedata[7:0];
    end

    always @(posedge core_clk) begin
        if (!nrst) begin
            periph_enable_regs <= `RST_PERIPH_EN;
        end else begin
            periph_enable_regs <= next_periph_enable;
        end
    end

    // Core entry and return take precedence over software writes
    wire take_irq = irq_ack & irq_request;
    reg  next_global_disable;
    always @* begin
        next_global_disable = global_irq_disable;
        if (take_irq)
            next_global_disable = 1'b1;
        else if (return_from_irq)
            next_global_disable = 1'b0;
        else if (wr_cpu_status)
            next_global_disable = writedata[`BIT_GLOBAL_DISABLE];
    end

    always @(posedge core_clk) begin
        if (!nrst) begin
            global_irq_disable <= 1'b1;
        end else begin
            global_irq_disable <= next_global_disable;
        end
    end

    // Stack handshake toward the core sequencer
    always @(posedge core_clk) begin
        if (!nrst) begin
            stack_push      <= 1'b0;
            stack_push_data <= 16'h0000;
            stack_pop       <= 1'b0;
        end else begin
            stack_push <= take_irq;
            stack_pop  <= return_from_irq & ~take_irq;
            if (take_irq)
                stack_push_data <= return_pc;
        end
    end
endmodule // four_vector_interrupt_logic

// file: testbench/four_vector_interrupt_logic_properties.sv
// Port-level checker for the four-vector interrupt logic
`timescale 1ns/10ps
`include "irq_logic_regs.vh"
module irq_logic_checker (
    input wire        core_clk,
    input wire        nrst,
    input wire        read,
    input wire        write,
    input wire        waitrequest,
    input wire        irq_ack,
    input wire        irq_request,
    input wire [15:0] return_pc,
    input wire        return_from_irq,
    input wire        stack_push,
    input wire [15:0] stack_push_data,
    input wire        stack_pop,
    input wire [15:0] irq_vector,
    input wire        wake,
    input wire        core_sleeping
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    a_one_wait: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("bus wait not one cycle");
    a_push_on_ack: assert property (irq_ack && irq_request |=> stack_push
        && stack_push_data == $past(return_pc)) else $error("no push of return pc");
    a_ack_masks: assert property (irq_ack && irq_request |=> !irq_request)
        else $error("request after ack");
    a_push_cause: assert property (stack_push |-> $past(irq_ack && irq_request))
        else $error("push without ack");
    a_pop_on_return: assert property (return_from_irq |=> stack_pop)
        else $error("no pop after return");
    a_reset_masks: assert property (!$past(nrst) |-> !irq_request)
        else $error("request right after reset");
    a_request_vector: assert property (irq_request |-> irq_vector != `VEC_NONE)
        else $error("request without vector");
    a_wake_sleep: assert property (wake |-> core_sleeping)
        else $error("wake while awake");
endmodule // irq_logic_checker

bind four_vector_interrupt_logic irq_logic_checker i_chk (
    .core_clk(core_clk), .nrst(nrst), .read(read), .write(write),
    .waitrequest(waitrequest), .irq_ack(irq_ack), .irq_request(irq_request),
    .return_pc(return_pc), .return_from_irq(return_from_irq), .stack_push(stack_push),
    .stack_push_data(stack_push_data), .stack_pop(stack_pop), .irq_vector(irq_vector),
    .wake(wake), .core_sleeping(core_sleeping)
);

// file: testbench/core_model.sv
// Core sequencer model that takes interrupts and supplies return addresses
`timescale 1ns/10ps
module core_model (
    input  wire         core_clk,
    input  wire         nrst,
    input  wire         irq_request,
    input  wire         hold_ack,
    output logic        irq_ack = 1'b0,
    output logic [15:0] return_pc = 16'h0100
);
    always @(posedge core_clk) begin
        if (!nrst) begin
            irq_ack <= 1'b0;
            return_pc <= 16'h0100;
        end else begin
            irq_ack <= irq_request && !irq_ack && !hold_ack;
            if (irq_ack)
                return_pc <= return_pc + 16'h0010;
        end
    end
endmodule // core_model

// file: testbench/four_vector_interrupt_logic_bench.sv
// Self-checking bench for the four-vector interrupt logic
`timescale 1ns/10ps
`include "irq_logic_regs.vh"
module four_vector_interrupt_logic_bench;
    logic        core_clk = 0, nrst = 0, read = 0, write = 0, waitrequest;
    logic [3:0]  address = 4'h0;
    logic [31:0] writedata = 32'h0, readdata, q;
    logic        ext_irq_pin = 1, timer_clock_pin = 1, timer_overflow_event = 0;
    logic [7:0]  periph_event = 8'h00;
    logic        irq_ack, return_from_irq = 0, core_sleeping = 0, hold_ack = 1;
    logic        irq_request, stack_push, stack_pop, wake;
    logic [15:0] return_pc, irq_vector, stack_push_data;
    int          num_errors = 0, n_tests = 0, cycles = 0;

    four_vector_interrupt_logic i_dut (.core_clk(core_clk), .nrst(nrst), .address(address),
        .read(read), .write(write), .writedata(writedata), .byteenable(4'hf),
        .readdata(readdata), .waitrequest(waitrequest), .ext_irq_pin(ext_irq_pin),
        .timer_clock_pin(timer_clock_pin), .timer_overflow_event(timer_overflow_event),
        .periph_event(periph_event), .irq_ack(irq_ack), .return_from_irq(return_from_irq),
        .return_pc(return_pc), .core_sleeping(core_sleeping), .irq_request(irq_request),
        .irq_vector(irq_vector), .stack_push(stack_push), .stack_push_data(stack_push_data),
        .stack_pop(stack_pop), .wake(wake));
    core_model i_core (.core_clk(core_clk), .nrst(nrst), .irq_request(irq_request),
        .hold_ack(hold_ack), .irq_ack(irq_ack), .return_pc(return_pc));

    initial forever #20 core_clk = ~core_clk;

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            complete_run();
        end
    end
    task automatic chk(input string n, input [31:0] s, input [31:0] e);
        n_tests++;
        if (s !== e) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic bus(input [3:0] a, input w, input [7:0] d);
        @(posedge core_clk);
        address <= a;
        write <= w;
        read <= !w;
        writedata <= {24'h0, d};
        do @(posedge core_clk); while (waitrequest !== 1'b0);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask
    task automatic rd(input [3:0] a, input [7:0] e, input string n);
        bus(a, 1'b0, 8'h00);
        chk(n, q & 32'hff, {24'h0, e});
    endtask

    task automatic t_reset();
        rd(`OFS_CPU_STATUS, 8'h10, "cpu status");
        rd(`OFS_IRQ_STATUS, 8'h00, "irq status");
        rd(4'hf, 8'h00, "unmapped");
        $display("test reset done");
    endtask
    task automatic t_pins();
        bus(`OFS_CPU_STATUS, 1'b1, 8'h00);
        bus(`OFS_TIMER_STATUS, 1'b1, 8'h80);
        ext_irq_pin <= 1'b0;
        timer_clock_pin <= 1'b0;
        repeat (8) @(posedge core_clk);
        rd(`OFS_IRQ_STATUS, 8'h40, "falling edges");
        ext_irq_pin <= 1'b1;
        repeat (8) @(posedge core_clk);
        rd(`OFS_IRQ_STATUS, 8'h50, "rising edge");
        chk("masked request", irq_request, 1'b0);
        core_sleeping <= 1'b1;
        bus(`OFS_IRQ_STATUS, 1'b1, 8'h11);
        @(posedge core_clk);
        chk("ext wake", wake, 1'b1);
        bus(`OFS_IRQ_STATUS, 1'b1, 8'h44);
        @(posedge core_clk);
        chk("count wake", wake, 1'b1);
        chk("count vector", irq_vector, 16'h0018);
        bus(`OFS_IRQ_STATUS, 1'b1, 8'h00);
        core_sleeping <= 1'b0;
        $display("test pins done");
    endtask
    task automatic t_prio();
        logic [3:0] ca [4] = '{4'h0, 4'h0, 4'h0, 4'h3};
        logic [7:0] cd [4] = '{8'h6f, 8'h4f, 8'h0f, 8'h00};
        bus(`OFS_CPU_STATUS, 1'b1, 8'h10);
        timer_overflow_event <= 1'b1;
        periph_event <= 8'h01;
        @(posedge core_clk);
        timer_overflow_event <= 1'b0;
        periph_event <= 8'h00;
        bus(`OFS_PERIPH_ENABLE, 1'b1, 8'h01);
        bus(`OFS_IRQ_STATUS, 1'b1, 8'h7f);
        rd(`OFS_IRQ_STATUS, 8'hff, "summary flag");
        bus(`OFS_CPU_STATUS, 1'b1, 8'h00);
        hold_ack <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            for (int k = 0; k < 20 && stack_push !== 1'b1; k++) @(posedge core_clk);
            chk("vector", irq_vector, 16'h0008 * (i + 1));
            chk("saved pc", stack_push_data, 16'h0100 + 16'h0010 * i);
            bus(ca[i], 1'b1, cd[i]);
            return_from_irq <= 1'b1;
            @(posedge core_clk);
            return_from_irq <= 1'b0;
            @(posedge core_clk);
            chk("pop", stack_pop, 1'b1);
        end
        $display("test priority done");
    endtask
    task automatic t_wake();
        hold_ack <= 1'b1;
        core_sleeping <= 1'b1;
        repeat (2) @(posedge core_clk);
        chk("idle wake", wake, 1'b0);
        periph_event <= 8'h01;
        @(posedge core_clk);
        periph_event <= 8'h00;
        repeat (2) @(posedge core_clk);
        chk("wake", wake, 1'b1);
        $display("test wake done");
    endtask

    initial begin
        repeat (3) @(posedge core_clk);
        nrst <= 1'b1;
        t_reset();
        t_pins();
        t_prio();
        t_wake();
        complete_run();
    end
endmodule // four_vector_interrupt_logic_bench
